// file: step_power_pkg.sv
// Purpose: constants and types for the divider step and channel power registers
// Assumes: 16-bit registers reached at word addresses over an internal register port
// Notes:   the rules of the block are listed below
// Overview of operation
// - bits 8 and 7 include integer dividers of channels 2 and 1 in stepping.
// - bits 6..3 include fractional dividers of channels 4..1 in stepping.
// - self-clearing bit 2 decrements included words by their step sizes.
// - self-clearing bit 1 increments included words by their step sizes.
// - bit 0 picks stepping source: 0 pins, 1 register bits.
// - power bits 7,5,3,1 switch off regulators of channels 4,3,2,1.
// - power bits 6,4,2,0 switch off fractional dividers of channels 4..1.
// - power register at address 4, resets to 54h.
// - power bits 15..8 are plain read/write storage, reset zero.
// - bits 10 and 9 include integer dividers of channels 4 and 3.
// - step register at address 3 resets to zero, pin mode, nothing pending.
package step_power_pkg;
  localparam logic [7:0]  ADDR_STEP_CTRL  = 8'h03;
  localparam logic [7:0]  ADDR_POWER_DOWN = 8'h04;
  localparam logic [15:0] RESET_STEP_CTRL = 16'h0000;
  localparam logic [15:0] RESET_POWER     = 16'h0054;
  localparam int BIT_REG_MODE  = 0;
  localparam int BIT_INC       = 1;
  localparam int BIT_DEC       = 2;
  localparam int BIT_FRAC_LO   = 3;
  localparam int BIT_INT_LO    = 7;
  localparam int N_CH          = 4;

  typedef struct packed {
    logic [3:0] int_step;
    logic [3:0] frac_step;
    logic       up;
    logic       down;
  } step_cmd_type;
endpackage : step_power_pkg

// file: divider_step_and_channel_power.sv
// Purpose: step-control and channel power-down registers with step request generation
// Assumes: pin requests are asynchronous levels; a step fires on their rising edge
// Notes:   step outputs are one-cycle pulses carrying per-channel include masks
`timescale 1ns/1ps
`default_nettype none
module divider_step_and_channel_power (
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  input  wire logic [7:0]                  reg_addr,
  input  wire logic                        reg_wr,
  input  wire logic [15:0]                 reg_wdata,
  output var  logic [15:0]                 reg_rdata,
  input  wire logic                        pin_freq_up,
  input  wire logic                        pin_freq_down,
  output var  step_power_pkg::step_cmd_type step_cmd,
  output var  logic [3:0]                  regulator_off,
  output var  logic [3:0]                  frac_div_off
);
  logic [15:0] step_r, step_nxt, pwr_r, pwr_nxt, rdata_r, rdata_nxt;
  logic [2:0]  up_sync_r, dn_sync_r;
  step_power_pkg::step_cmd_type cmd_r, cmd_nxt;
  logic pin_up_edge, pin_dn_edge, req_up, req_dn;

  // only the second and third stages feed the edge detector
  assign pin_up_edge = up_sync_r[1] & ~up_sync_r[2];
  assign pin_dn_edge = dn_sync_r[1] & ~dn_sync_r[2];

  always_comb begin
    step_nxt = step_r;
    pwr_nxt  = pwr_r;
    step_nxt[step_power_pkg::BIT_INC] = 1'b0;
    step_nxt[step_power_pkg::BIT_DEC] = 1'b0;
    if (reg_wr && reg_addr == step_power_pkg::ADDR_STEP_CTRL) begin
      step_nxt = reg_wdata;
    end
    if (reg_wr && reg_addr == step_power_pkg::ADDR_POWER_DOWN) begin
      pwr_nxt = reg_wdata;
    end
    if (reg_addr == step_power_pkg::ADDR_STEP_CTRL) begin
      rdata_nxt = step_r;
    end else if (reg_addr == step_power_pkg::ADDR_POWER_DOWN) begin
      rdata_nxt = pwr_r;
    end else begin
      rdata_nxt = 16'h0000;
    end
  end

  always_comb begin
    if (step_r[step_power_pkg::BIT_REG_MODE]) begin
      req_up = step_r[step_power_pkg::BIT_INC];
      req_dn = step_r[step_power_pkg::BIT_DEC];
    end else begin
      req_up = pin_up_edge;
      req_dn = pin_dn_edge;
    end
    cmd_nxt.int_step  = step_r[step_power_pkg::BIT_INT_LO +: step_power_pkg::N_CH];
    cmd_nxt.frac_step = step_r[step_power_pkg::BIT_FRAC_LO +: step_power_pkg::N_CH];
    // opposing requests cancel so the divider words hold
    cmd_nxt.up   = req_up & ~req_dn;
    cmd_nxt.down = req_dn & ~req_up;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      step_r    <= step_power_pkg::RESET_STEP_CTRL;
      pwr_r     <= step_power_pkg::RESET_POWER;
      rdata_r   <= 16'h0000;
      cmd_r     <= '0;
      up_sync_r <= 3'h0;
      dn_sync_r <= 3'h0;
    end else begin
      step_r    <= step_nxt;
      pwr_r     <= pwr_nxt;
      rdata_r   <= rdata_nxt;
      cmd_r     <= cmd_nxt;
      up_sync_r <= {up_sync_r[1:0], pin_freq_up};
      dn_sync_r <= {dn_sync_r[1:0], pin_freq_down};
    end
  end

  assign reg_rdata     = rdata_r;
  assign step_cmd      = cmd_r;
  assign regulator_off = {pwr_r[7], pwr_r[5], pwr_r[3], pwr_r[1]};
  assign frac_div_off  = {pwr_r[6], pwr_r[4], pwr_r[2], pwr_r[0]};

  // a fresh write may set the bit again, so only an unrewritten bit must drop
  step_bits_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (step_r[step_power_pkg::BIT_INC]
     && !(reg_wr && reg_addr == step_power_pkg::ADDR_STEP_CTRL))
    |=> !step_r[step_power_pkg::BIT_INC]) else $error("increment bit did not self-clear");
  dec_bit_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (step_r[step_power_pkg::BIT_DEC]
     && !(reg_wr && reg_addr == step_power_pkg::ADDR_STEP_CTRL))
    |=> !step_r[step_power_pkg::BIT_DEC]) else $error("decrement bit did not self-clear");
  reg_mode_pin_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (step_r[step_power_pkg::BIT_REG_MODE] && !step_r[step_power_pkg::BIT_INC])
    |=> !cmd_r.up) else $error("pin step taken in register mode");
  int_mask_hi_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    1'b1 |=> cmd_r.int_step[3:2] == $past(step_r[10:9])) else $error("upper integer mask wrong");
  frac_power_map_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    frac_div_off == {pwr_r[6], pwr_r[4], pwr_r[2], pwr_r[0]}) else $error("fraction power map wrong");
  reg_step_up_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (step_r[0] && step_r[1] && !step_r[2]) |=> cmd_r.up) else $error("register increment lost");
  reg_step_down_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (step_r[0] && step_r[2] && !step_r[1]) |=> cmd_r.down) else $error("register decrement lost");
  both_cancel_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(cmd_r.up && cmd_r.down)) else $error("up and down at once");
  pin_mode_src_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!step_r[0] && !pin_up_edge) |=> !cmd_r.up) else $error("step up without pin edge");
  int_mask_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    1'b1 |=> cmd_r.int_step == $past(step_r[10:7])) else $error("integer mask mismatch");
  frac_mask_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    1'b1 |=> cmd_r.frac_step == $past(step_r[6:3])) else $error("fraction mask mismatch");
  power_map_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    regulator_off[3] == pwr_r[7] && frac_div_off[0] == pwr_r[0]) else $error("power map wrong");
  power_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == step_power_pkg::ADDR_POWER_DOWN) |=> pwr_r == $past(reg_wdata))
    else $error("power write lost");
  reset_vals_a: assert property (@(posedge ref_clk)
    !rst_n |=> (pwr_r == 16'h0054 && step_r == 16'h0000)) else $error("bad reset values");
endmodule : divider_step_and_channel_power
`default_nettype wire

// file: tb_divider_step_and_channel_power.sv
// Purpose: self-checking bench for the step-control and channel power registers
// Assumes: inputs change 1 ns after the rising edge of ref_clk
// Notes:   the pin path is awaited under a bound because edge detection adds latency
`timescale 1ns/1ps
`default_nettype none
module tb_divider_step_and_channel_power;
  logic                         ref_clk, rst_n, reg_wr, pin_freq_up, pin_freq_down;
  logic [7:0]                   reg_addr;
  logic [15:0]                  reg_wdata, reg_rdata;
  step_power_pkg::step_cmd_type step_cmd;
  logic [3:0]                   regulator_off, frac_div_off;
  int                           fail_count = 0;
  int                           n_compared = 0;
  // addr, write data, expected read, expected {regulator_off, frac_div_off}
  logic [47:0] rows [4] = '{48'h04_00AA_00AA_F0, 48'h04_FF55_FF55_0F,
                            48'h03_07F8_07F8_0F, 48'h05_FFFF_0000_0F};
  divider_step_and_channel_power dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .pin_freq_up(pin_freq_up), .pin_freq_down(pin_freq_down), .step_cmd(step_cmd),
    .regulator_off(regulator_off), .frac_div_off(frac_div_off));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    reg_addr = a;
    tick(1);
    chk(reg_rdata, exp);
  endtask : rd
  // pulse stands for the one cycle after the edge that follows the write edge
  task automatic step(input logic [15:0] d, input logic [1:0] exp);
    wr(8'h03, d);
    tick(1);
    chk({14'h0000, step_cmd.up, step_cmd.down}, {14'h0000, exp});
    tick(1);
    chk({15'h0000, step_cmd.up | step_cmd.down}, 16'h0000);
  endtask : step
  initial begin
    {rst_n, reg_wr, pin_freq_up, pin_freq_down, reg_addr, reg_wdata} = '0;
    tick(4);
    chk({8'h00, regulator_off, frac_div_off}, 16'h000E);
    rst_n = 1'b1;
    rd(8'h03, 16'h0000);
    rd(8'h04, 16'h0054);
    foreach (rows[i]) begin
      wr(rows[i][47:40], rows[i][39:24]);
      rd(rows[i][47:40], rows[i][23:8]);
      chk({8'h00, regulator_off, frac_div_off}, {8'h00, rows[i][7:0]});
    end
    chk({8'h00, step_cmd.int_step, step_cmd.frac_step}, 16'h00FF);
    step(16'h0083, 2'b10);
    rd(8'h03, 16'h0081);
    step(16'h0085, 2'b01);
    step(16'h0087, 2'b00);
    step(16'h0082, 2'b00);
    pin_freq_up = 1'b1;
    repeat (8) if (step_cmd.up !== 1'b1) tick(1);
    chk({15'h0000, step_cmd.up}, 16'h0001);
    pin_freq_up = 1'b0;
    tick(2);
    pin_freq_down = 1'b1;
    repeat (8) if (step_cmd.down !== 1'b1) tick(1);
    chk({15'h0000, step_cmd.down}, 16'h0001);
    pin_freq_down = 1'b0;
    wr(8'h03, 16'h0001);
    tick(3);
    pin_freq_up = 1'b1;
    repeat (8) begin
      tick(1);
      chk({15'h0000, step_cmd.up}, 16'h0000);
    end
    pin_freq_up = 1'b0;
    tick(3);
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    rd(8'h03, 16'h0000);
    rd(8'h04, 16'h0054);
    chk({8'h00, regulator_off, frac_div_off}, 16'h000E);
    end_sim();
  end
  initial begin
    #20000;
    fail_count++;
    end_sim();
  end
endmodule : tb_divider_step_and_channel_power
`default_nettype wire
